// ### bench/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model
#(
	parameter logic [6:0] ADDR = 7'h2a
)
(
	input wire logic clk,
	input wire logic sdaOut,
	input wire logic sdaOe_n,
	output logic scl,
	output logic sda
);
	logic drv = 1'b1;
	logic [7:0] junk;
	logic ack;
	initial scl = 1'b1;
	// pull-up: a released line reads high
	assign sda = drv & (sdaOe_n | sdaOut);
	task automatic hp;
		repeat (6) @(negedge clk);
	endtask
	task automatic start;
		drv = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		drv = 1'b0;
		hp();
		scl = 1'b0;
	endtask
	task automatic stop;
		drv = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		drv = 1'b1;
		hp();
	endtask
	// ninth slot is left released, which is a nack on reads
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic a);
		for (int i = 7; i >= -1; i--)
		begin
			drv = (i < 0) ? 1'b1 : tx[i];
			hp();
			scl = 1'b1;
			hp();
			if (i >= 0)
				rx[i] = sda;
			else
				a = !sda;
			scl = 1'b0;
		end
	endtask
	task automatic wr(input logic [7:0] p, d);
		start();
		xfer({ADDR, 1'b0}, junk, ack);
		xfer(p, junk, ack);
		xfer(d, junk, ack);
		stop();
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		start();
		xfer({ADDR, 1'b0}, junk, ack);
		xfer(p, junk, ack);
		start();
		xfer({ADDR, 1'b1}, junk, ack);
		xfer(8'hff, d, ack);
		stop();
	endtask
endmodule

// ### bench/thermo_monitor.sv
`timescale 1ns/1ps
module thermo_monitor
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sampleValid,
	input wire logic signed [15:0] hotSample,
	input wire logic rangeExceeded,
	input wire logic [63:0] alertLimits,
	input wire logic [3:0] alertUseCold,
	input wire logic [15:0] deltaTemp,
	input wire logic [15:0] hotTemp,
	input wire logic [15:0] coldTemp,
	input wire thermo_pkg::thermo_type_t thermoType,
	input wire logic shutdownReq,
	input wire logic [7:0] statusFlags,
	input wire logic [7:0] sensorCfg
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	logic [3:0] alertCalc;
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			alertCalc[i] = $signed(alertUseCold[i] ? coldTemp : hotTemp)
				> $signed(alertLimits[16*i +: 16]);
		end
	end
	AST_RANGE_FLAG: assert property (1'b1 |=> statusFlags[4] == $past(rangeExceeded))
		else $error("range flag wrong");
	AST_RANGE_HOLD: assert property (sampleValid && rangeExceeded |=>
		$stable(hotTemp) && $stable(coldTemp) ##1 $stable(deltaTemp)) else $error("held data moved");
	AST_UPDATE_SET: assert property (sampleValid && !rangeExceeded |-> ##2 statusFlags[6])
		else $error("update flag missing");
	AST_ALERT_CMP: assert property (1'b1 |=> statusFlags[3:0] == $past(alertCalc))
		else $error("alert bits wrong");
	AST_BYPASS: assert property (sampleValid && !rangeExceeded && sensorCfg[2:0] == 3'h0
		|-> ##2 deltaTemp == $past(hotSample, 2)) else $error("bypass wrong");
	AST_CFG_FIELDS: assert property (thermoType == sensorCfg[6:4] && !sensorCfg[7]
		&& !sensorCfg[3] && !statusFlags[5]) else $error("config fields wrong");
	// the done pulse is registered once more into the status image, one cycle after shutdown
	AST_BURST_DONE: assert property ($rose(shutdownReq) |-> statusFlags[6] ##1 statusFlags[7])
		else $error("burst flag missing");
	AST_DELTA_CAUSE: assert property ($changed(deltaTemp) |->
		$past(sampleValid, 2) && !$past(rangeExceeded, 2)) else $error("stray delta change");
endmodule
bind thermo_status_config_filter thermo_monitor u_mon
(
	.core_clk, .rst_n, .sampleValid, .hotSample, .rangeExceeded, .alertLimits,
	.alertUseCold, .deltaTemp, .hotTemp, .coldTemp, .thermoType, .shutdownReq,
	.statusFlags, .sensorCfg
);

// ### bench/thermo_status_config_filter_tb.sv
`timescale 1ns/1ps
module thermo_status_config_filter_tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic sampleValid = 1'b0;
	logic rangeExceeded = 1'b0;
	logic burstMode = 1'b0;
	logic burstStart = 1'b0;
	logic [2:0] burstSamples = 3'h0;
	logic signed [15:0] hotSample = 16'h0000, hotCompSample = 16'h0000, coldSample = 16'h0000;
	logic [63:0] alertLimits = 64'h0;
	logic [3:0] alertUseCold = 4'h0;
	logic sclIn, sdaIn, sdaOut, sdaOe_n, shutdownReq, a;
	logic [15:0] deltaTemp, hotTemp, coldTemp, hold;
	logic [7:0] statusFlags, sensorCfg, rd, v;
	logic [2:0] vp = 3'h0;
	thermo_pkg::thermo_type_t thermoType;
	logic [15:0] expQ[$];
	int err_count = 0, checks = 0, cyc = 0, y = 0, n = 0;
	bit first = 1'b1;
	always #4 core_clk = ~core_clk;
	thermo_status_config_filter DUT (.core_clk, .rst_n, .sclIn, .sdaIn, .sdaOut, .sdaOe_n,
		.devAddr(7'h2a), .sampleValid, .hotSample, .hotCompSample, .coldSample, .rangeExceeded,
		.alertLimits, .alertUseCold, .burstMode, .burstStart, .burstSamples, .deltaTemp,
		.hotTemp, .coldTemp, .thermoType, .shutdownReq, .statusFlags, .sensorCfg);
	i2c_host_model host (.clk(core_clk), .sdaOut, .sdaOe_n, .scl(sclIn), .sda(sdaIn));
	task automatic check(input logic [15:0] got, exp, input string m);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic give_verdict;
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic smp(input logic signed [15:0] x, input logic r);
		@(negedge core_clk);
		sampleValid = 1'b1;
		hotSample = x;
		hotCompSample = 16'($urandom);
		coldSample = 16'($urandom);
		rangeExceeded = r;
		if (!r)
		begin
			y = first ? x : y + 2 * (x - y) / ((1 << n) + 1);
			first = 1'b0;
			expQ.push_back(y[15:0]);
		end
		@(negedge core_clk);
		sampleValid = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask
	always @(posedge core_clk)
		vp <= {vp[1:0], sampleValid & ~rangeExceeded};
	always @(negedge core_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			err_count++;
			give_verdict();
		end
		if (vp[2])
		begin
			check(deltaTemp, expQ.pop_front(), "filtered value");
			check(statusFlags[6], 1'b1, "update flag");
		end
	end
	initial
	begin
		void'($urandom(36));
		alertLimits = {$urandom, $urandom};
		alertUseCold = 4'($urandom);
		repeat (8) @(negedge core_clk);
		// alert bits follow the random limits from the first edge after release
		check(statusFlags, 8'h00, "status reset");
		check(sensorCfg, 8'h00, "config reset");
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		for (int t = 0; t < 8; t++)
		begin
			v = 8'($urandom);
			v[6:4] = t[2:0];
			v[2:0] = 3'(7 - t);
			host.wr(8'h05, v);
			n = v[2:0];
			first = 1'b1;
			host.rd(8'h05, rd);
			check(rd, v & 8'h77, "config readback");
			check(thermoType, t[2:0], "type select");
			repeat (3) smp(16'($urandom), 1'b0);
		end
		hold = hotCompSample;
		smp(16'($urandom), 1'b1);
		check(hotTemp, hold, "hot held");
		check(deltaTemp, y[15:0], "delta held");
		host.rd(8'h04, rd);
		check(rd[4], 1'b1, "range flag");
		host.wr(8'h04, 8'hff);
		host.rd(8'h04, rd);
		check(rd[6], 1'b1, "flag kept");
		smp(16'($urandom), 1'b0);
		host.wr(8'h04, 8'h00);
		host.rd(8'h04, rd);
		check(rd[7:4], 4'h0, "flags cleared");
		for (int i = 0; i < 4; i++)
		begin
			a = $signed(alertLimits[16*i +: 16]) < (alertUseCold[i] ? coldSample : hotCompSample);
			check(rd[i], a, "alert status");
		end
		check(hotTemp, hotCompSample, "hot stored");
		check(coldTemp, coldSample, "cold stored");
		burstMode = 1'b1;
		burstSamples = 3'h2;
		@(negedge core_clk);
		burstStart = 1'b1;
		@(negedge core_clk);
		burstStart = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			check(shutdownReq, 1'b0, "early shutdown");
			smp(16'($urandom), 1'b0);
		end
		check(shutdownReq, 1'b1, "burst shutdown");
		host.rd(8'h04, rd);
		check(rd[7], 1'b1, "burst done");
		give_verdict();
	end
endmodule

// ### rtl/burst_sequencer.sv
`timescale 1ns/1ps
module burst_sequencer
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic burstMode,
	input wire logic burstStart,
	input wire logic [2:0] sampleCount,
	input wire logic convDone,
	output logic burstDone,
	output logic shutdownReq
);

	logic active;
	logic [7:0] count;
	logic [8:0] target;
	logic [8:0] nextCount;

	assign target = 9'h001 << sampleCount; // 1 to 128 samples
	assign nextCount = {1'b0, count} + 9'h001;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			active <= 1'b0;
			count <= 8'h00;
			burstDone <= 1'b0;
			shutdownReq <= 1'b0;
		end
		else
		begin
			burstDone <= 1'b0;
			if (burstStart && burstMode)
			begin
				active <= 1'b1;
				count <= 8'h00;
				shutdownReq <= 1'b0;
			end
			else if (active && convDone)
			begin
				if (nextCount == target)
				begin
					active <= 1'b0;
					count <= 8'h00;
					burstDone <= 1'b1;
					shutdownReq <= 1'b1;
				end
				else
					count <= nextCount[7:0];
			end
		end
	end

endmodule

// ### rtl/ema_filter.sv
`timescale 1ns/1ps
module ema_filter
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sampleValid,
	input wire logic signed [15:0] sample,
	input wire logic [2:0] coeff,
	input wire logic clearState,
	output logic signed [15:0] filtered,
	output logic outValid
);

	logic hasHistory;
	logic signed [16:0] diff;
	logic signed [17:0] twiceDiff;
	logic signed [17:0] step;
	logic signed [17:0] sum;

	// y += 2*(x-y)/(2^n+1), i.e. k*x + (1-k)*y with k = 2/(2^n+1)
	function automatic logic signed [17:0] ema_step(input logic signed [17:0] num,
		input logic [2:0] n);
		case (n)
			3'h1: ema_step = num / 18'sd3;
			3'h2: ema_step = num / 18'sd5;
			3'h3: ema_step = num / 18'sd9;
			3'h4: ema_step = num / 18'sd17;
			3'h5: ema_step = num / 18'sd33;
			3'h6: ema_step = num / 18'sd65;
			3'h7: ema_step = num / 18'sd129;
			default: ema_step = num;
		endcase
	endfunction

	assign diff = {sample[15], sample} - {filtered[15], filtered};
	assign twiceDiff = {diff, 1'b0};
	assign step = ema_step(twiceDiff, coeff);
	// result always lies between old output and sample, so the top bits drop safely
	assign sum = {{2{filtered[15]}}, filtered} + step;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			filtered <= 16'sh0000;
		else if (sampleValid)
		begin
			if (!hasHistory || coeff == 3'h0)
				filtered <= sample;
			else
				filtered <= sum[15:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			hasHistory <= 1'b0;
		else if (clearState)
			hasHistory <= 1'b0;
		else if (sampleValid)
			hasHistory <= 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			outValid <= 1'b0;
		else
			outValid <= sampleValid;
	end

endmodule

// ### rtl/thermo_cfg.svh
`ifndef THERMO_CFG_SVH
`define THERMO_CFG_SVH

// register pointers on the serial port
`define STATUS_PTR 8'h04
`define SENSOR_CFG_PTR 8'h05

// status register fields
`define STAT_BURST_BIT 7
`define STAT_UPDATE_BIT 6
`define STAT_RANGE_BIT 4
`define STAT_ALERT_HI 3
`define STAT_ALERT_LO 0
`define STATUS_RESET 8'h00

// sensor configuration fields
`define CFG_TYPE_HI 6
`define CFG_TYPE_LO 4
`define CFG_COEFF_HI 2
`define CFG_COEFF_LO 0
`define SENSOR_CFG_RESET 8'h00
`define SENSOR_CFG_MASK 8'h77

// serial port
`define DEV_ADDR_RESET 7'h60
`define READ_FILL 8'h00

`endif

// ### rtl/thermo_pkg.sv
package thermo_pkg;

	typedef enum logic [4:0] {
		PORT_IDLE = 5'b00001,
		PORT_RX = 5'b00010,
		PORT_ACK = 5'b00100,
		PORT_TX = 5'b01000,
		PORT_RACK = 5'b10000
	} port_state_t;

	typedef enum logic [2:0] {
		TC_K = 3'h0,
		TC_J = 3'h1,
		TC_T = 3'h2,
		TC_N = 3'h3,
		TC_S = 3'h4,
		TC_E = 3'h5,
		TC_B = 3'h6,
		TC_R = 3'h7
	} thermo_type_t;

endpackage

// ### rtl/thermo_status_config_filter.sv
`timescale 1ns/1ps
`include "thermo_cfg.svh"
module thermo_status_config_filter
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe_n,
	input wire logic [6:0] devAddr,
	input wire logic sampleValid,
	input wire logic signed [15:0] hotSample,
	input wire logic signed [15:0] hotCompSample,
	input wire logic signed [15:0] coldSample,
	input wire logic rangeExceeded,
	input wire logic [63:0] alertLimits,
	input wire logic [3:0] alertUseCold,
	input wire logic burstMode,
	input wire logic burstStart,
	input wire logic [2:0] burstSamples,
	output logic [15:0] deltaTemp,
	output logic [15:0] hotTemp,
	output logic [15:0] coldTemp,
	output thermo_pkg::thermo_type_t thermoType,
	output logic shutdownReq,
	output logic [7:0] statusFlags,
	output logic [7:0] sensorCfg
);

	// serial port: pins are asynchronous to core_clk
	logic sclMeta, sclSync, sclPrev;
	logic sdaMeta, sdaSync, sdaPrev;
	logic sclRise, sclFall, startSeen, stopSeen;
	thermo_pkg::port_state_t portState;
	logic [3:0] bitCnt;
	logic [7:0] shiftReg;
	logic firstByte, secondByte, readDir, masterNack;
	logic [7:0] regPtr;
	logic wrStrobe;
	logic [7:0] wrData;
	logic [7:0] rdData;

	// conversion path
	logic convValid;
	logic signed [15:0] filtOut;
	logic filtValid;
	logic burstDone;
	logic cfgWrite;
	logic statusWrite;
	logic [3:0] alertBits;

	function automatic logic [7:0] read_mux(input logic [7:0] ptr, input logic [7:0] stat,
		input logic [7:0] cfg);
		case (ptr)
			`STATUS_PTR: read_mux = stat;
			`SENSOR_CFG_PTR: read_mux = cfg & `SENSOR_CFG_MASK;
			default: read_mux = `READ_FILL;
		endcase
	endfunction

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclMeta <= 1'b1;
			sclSync <= 1'b1;
			sclPrev <= 1'b1;
			sdaMeta <= 1'b1;
			sdaSync <= 1'b1;
			sdaPrev <= 1'b1;
		end
		else
		begin
			sclMeta <= sclIn;
			sclSync <= sclMeta;
			sclPrev <= sclSync;
			sdaMeta <= sdaIn;
			sdaSync <= sdaMeta;
			sdaPrev <= sdaSync;
		end
	end

	assign sclRise = sclSync & ~sclPrev;
	assign sclFall = ~sclSync & sclPrev;
	assign startSeen = sclSync & sclPrev & sdaPrev & ~sdaSync;
	assign stopSeen = sclSync & sclPrev & ~sdaPrev & sdaSync;
	assign rdData = read_mux(regPtr, statusFlags, sensorCfg);

	// open drain: only ever pull low, release otherwise
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			sdaOut <= 1'b0;
		else
			sdaOut <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			portState <= thermo_pkg::PORT_IDLE;
			bitCnt <= 4'h0;
			shiftReg <= 8'h00;
			firstByte <= 1'b0;
			secondByte <= 1'b0;
			readDir <= 1'b0;
			masterNack <= 1'b0;
			regPtr <= 8'h00;
			wrStrobe <= 1'b0;
			wrData <= 8'h00;
			sdaOe_n <= 1'b1;
		end
		else
		begin
			wrStrobe <= 1'b0;
			if (startSeen)
			begin
				portState <= thermo_pkg::PORT_RX;
				bitCnt <= 4'h0;
				firstByte <= 1'b1;
				sdaOe_n <= 1'b1;
			end
			else if (stopSeen)
			begin
				portState <= thermo_pkg::PORT_IDLE;
				sdaOe_n <= 1'b1;
			end
			else
			begin
				case (portState)
					thermo_pkg::PORT_IDLE:
						sdaOe_n <= 1'b1;
					thermo_pkg::PORT_RX:
						if (sclRise)
						begin
							shiftReg <= {shiftReg[6:0], sdaSync};
							bitCnt <= bitCnt + 4'h1;
						end
						else if (sclFall && bitCnt == 4'h8)
						begin
							bitCnt <= 4'h0;
							if (firstByte)
							begin
								firstByte <= 1'b0;
								if (shiftReg[7:1] == devAddr)
								begin
									readDir <= shiftReg[0];
									secondByte <= ~shiftReg[0];
									sdaOe_n <= 1'b0;
									portState <= thermo_pkg::PORT_ACK;
								end
								else
									portState <= thermo_pkg::PORT_IDLE;
							end
							else
							begin
								if (secondByte)
									regPtr <= shiftReg;
								else
								begin
									wrStrobe <= 1'b1;
									wrData <= shiftReg;
								end
								secondByte <= 1'b0;
								sdaOe_n <= 1'b0;
								portState <= thermo_pkg::PORT_ACK;
							end
						end
					thermo_pkg::PORT_ACK:
						if (sclFall)
						begin
							if (readDir)
							begin
								shiftReg <= rdData;
								sdaOe_n <= rdData[7];
								bitCnt <= 4'h1;
								portState <= thermo_pkg::PORT_TX;
							end
							else
							begin
								sdaOe_n <= 1'b1;
								portState <= thermo_pkg::PORT_RX;
							end
						end
					thermo_pkg::PORT_TX:
						if (sclFall)
						begin
							if (bitCnt == 4'h8)
							begin
								sdaOe_n <= 1'b1;
								portState <= thermo_pkg::PORT_RACK;
							end
							else
							begin
								sdaOe_n <= shiftReg[6];
								shiftReg <= {shiftReg[6:0], 1'b0};
								bitCnt <= bitCnt + 4'h1;
							end
						end
					thermo_pkg::PORT_RACK:
						if (sclRise)
							masterNack <= sdaSync;
						else if (sclFall)
						begin
							if (masterNack)
								portState <= thermo_pkg::PORT_IDLE;
							else
							begin
								shiftReg <= rdData;
								sdaOe_n <= rdData[7];
								bitCnt <= 4'h1;
								portState <= thermo_pkg::PORT_TX;
							end
						end
					default:
						portState <= thermo_pkg::PORT_IDLE;
				endcase
			end
		end
	end

	assign cfgWrite = wrStrobe && regPtr == `SENSOR_CFG_PTR;
	assign statusWrite = wrStrobe && regPtr == `STATUS_PTR;
	// a sample out of range never reaches the filter or the result registers
	assign convValid = sampleValid && !rangeExceeded;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			sensorCfg <= `SENSOR_CFG_RESET;
		else if (cfgWrite)
			sensorCfg <= wrData & `SENSOR_CFG_MASK;
	end

	// the engine reads the type at the start of each sample, so a write lands next sample
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			thermoType <= thermo_pkg::TC_K;
		else if (cfgWrite)
			thermoType <= thermo_pkg::thermo_type_t'(wrData[`CFG_TYPE_HI:`CFG_TYPE_LO]);
	end

	ema_filter u_filter
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.sampleValid(convValid),
		.sample(hotSample),
		.coeff(sensorCfg[`CFG_COEFF_HI:`CFG_COEFF_LO]),
		.clearState(cfgWrite),
		.filtered(filtOut),
		.outValid(filtValid)
	);

	burst_sequencer u_burst
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.burstMode(burstMode),
		.burstStart(burstStart),
		.sampleCount(burstSamples),
		.convDone(filtValid),
		.burstDone(burstDone),
		.shutdownReq(shutdownReq)
	);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			deltaTemp <= 16'h0000;
		else if (filtValid)
			deltaTemp <= filtOut;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hotTemp <= 16'h0000;
			coldTemp <= 16'h0000;
		end
		else if (convValid)
		begin
			hotTemp <= hotCompSample;
			coldTemp <= coldSample;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_alert
			logic signed [15:0] watched;
			assign watched = alertUseCold[gi] ? $signed(coldTemp) : $signed(hotTemp);
			assign alertBits[gi] = watched > $signed(alertLimits[gi*16 +: 16]);
		end
	endgenerate

	// hardware set beats a software clear arriving in the same cycle
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			statusFlags <= `STATUS_RESET;
		else
		begin
			if (burstDone)
				statusFlags[`STAT_BURST_BIT] <= 1'b1;
			else if (statusWrite && !wrData[`STAT_BURST_BIT])
				statusFlags[`STAT_BURST_BIT] <= 1'b0;
			if (filtValid)
				statusFlags[`STAT_UPDATE_BIT] <= 1'b1;
			else if (statusWrite && !wrData[`STAT_UPDATE_BIT])
				statusFlags[`STAT_UPDATE_BIT] <= 1'b0;
			statusFlags[5] <= 1'b0;
			statusFlags[`STAT_RANGE_BIT] <= rangeExceeded;
			statusFlags[`STAT_ALERT_HI:`STAT_ALERT_LO] <= alertBits;
		end
	end

endmodule
